// >>> verilog/dpmiq_pkg.sv
package dpmiq_pkg;

  // Clock and tick timing: the slow tick paces both the PWM phases and input sampling.
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_PERIOD_NS  = 2000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W      = 16;

  // Debounce window expressed as a count of samples taken one tick apart.
  localparam int DEBOUNCE_NS     = 10000000;
  localparam int DB_SAMPLES      = DEBOUNCE_NS / TICK_PERIOD_NS;
  localparam int DB_CNT_W        = 3;

  localparam int NUM_CH          = 48;
  localparam int PWM_CH          = 24;
  localparam int MODE_QCH        = 8;
  localparam int RSP_MAX         = 6;

  localparam logic [7:0] MAX_PWM_CH     = 8'h17;
  localparam logic [7:0] OP_MODE_QUERY  = 8'h01;
  localparam logic [7:0] OP_PWM_PROGRAM = 8'h02;
  localparam logic [7:0] OP_PWM_QUERY   = 8'h03;
  localparam logic [7:0] OP_INPUT_QUERY = 8'h04;

  localparam logic [1:0] PWM_PROG_ARGS  = 2'h3;
  localparam logic [1:0] PWM_QUERY_ARGS = 2'h1;
  localparam logic [2:0] MODE_RSP_LEN   = 3'h1;
  localparam logic [2:0] PWM_RSP_LEN    = 3'h2;
  localparam logic [2:0] INPUT_RSP_LEN  = 3'h6;

  localparam logic [7:0]  ACTIVE_RST    = 8'h00;
  localparam logic [7:0]  INACTIVE_RST  = 8'h01;
  localparam logic [7:0]  INACTIVE_MIN  = 8'h01;
  localparam logic [7:0]  PHASE_CNT_RST = 8'h01;
  localparam logic [23:0] MODE_RST      = 24'h000000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARGS = 3'b010,
    ST_RESP = 3'b100
  } dpmiq_state_t;

endpackage

// >>> verilog/dpmiq_pwm_chan.sv
`timescale 1ns/10ps
module dpmiq_pwm_chan
  import dpmiq_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       tick_i,
  input  wire logic       enable_i,
  input  wire logic       enter_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] active_i,
  input  wire logic [7:0] inactive_i,
  output logic      [7:0] active_o,
  output logic      [7:0] inactive_o,
  output logic            level_o
);
  import dpmiq_pkg::*;

  logic [7:0] active_reg;
  logic [7:0] active_next;
  logic [7:0] inactive_reg;
  logic [7:0] inactive_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       on_reg;
  logic       on_next;

  always_comb begin
    active_next   = active_reg;
    inactive_next = inactive_reg;
    if (enter_i) begin
      active_next   = ACTIVE_RST;  // [R18] [R12]
      inactive_next = INACTIVE_RST;
    end else if (wr_i && enable_i) begin  // [R7]
      active_next   = active_i;  // [R4]
      inactive_next = (inactive_i == 8'h00) ? INACTIVE_MIN : inactive_i;  // [R5]
    end
  end

  // Phase lengths are sampled only at a phase boundary, so new timing never cuts the running phase.
  always_comb begin
    on_next  = on_reg;
    cnt_next = cnt_reg;
    if (!enable_i) begin
      on_next  = 1'b0;  // [R19]
      cnt_next = PHASE_CNT_RST;
    end else if (tick_i) begin
      if (cnt_reg > 8'h01) begin
        cnt_next = cnt_reg - 8'h01;  // [R9]
      end else if (!on_reg && active_reg != 8'h00) begin
        on_next  = 1'b1;  // [R6]
        cnt_next = active_reg;
      end else begin
        on_next  = 1'b0;  // [R6] [R4]
        cnt_next = inactive_reg;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_reg   <= ACTIVE_RST;
      inactive_reg <= INACTIVE_RST;
      cnt_reg      <= PHASE_CNT_RST;
      on_reg       <= 1'b0;
    end else begin
      active_reg   <= active_next;
      inactive_reg <= inactive_next;
      cnt_reg      <= cnt_next;
      on_reg       <= on_next;
    end
  end

  assign active_o   = active_reg;
  assign inactive_o = inactive_reg;
  assign level_o    = on_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  inactive_nonzero_a: assert property (inactive_reg != 8'h00)  // [R5]
    else $error("inactive interval reached zero");
  level_on_tick_a: assert property ($changed(on_reg) && enable_i |-> $past(tick_i))  // [R9]
    else $error("pwm level changed off a tick boundary");
  enter_clears_a: assert property (enter_i |=> active_reg == 8'h00 && !on_reg)  // [R18]
    else $error("entering pwm mode did not clear active interval");
  std_unchanged_a: assert property (wr_i && !enable_i && !enter_i |=> $stable(active_reg) && $stable(inactive_reg))  // [R7]
    else $error("standard channel timing changed by a program command");

endmodule // dpmiq_pwm_chan

// >>> verilog/dpmiq_top.sv
// Function
// R1 - Mode query returns one byte, bit n is channel n mode, one means PWM.
// R2 - After module reset the mode query reports standard mode everywhere.
// R3 - PWM program takes channel, active interval, inactive interval; no reply.
// R4 - Active interval counts 2 ms units, 0 to 255; zero keeps output off.
// R5 - Inactive interval of zero is replaced by one.
// R6 - Output is active for active interval then inactive for inactive interval, repeating.
// R7 - Programming a channel in standard mode changes nothing.
// R8 - Program channel above 23 sets the error flag and changes no timing.
// R9 - New timing waits until the phase in progress has finished.
// R10 - PWM query takes a channel byte, replies active then inactive interval.
// R11 - PWM query channel above 23 sets the error flag.
// R12 - PWM query returns last programmed intervals, or defaults since entering PWM.
// R13 - Client trusts PWM query values only for channels in PWM mode.
// R14 - Input query replies six bytes, channels 7..0 first up to 47..40.
// R15 - Each input query bit is one when the debounced state is active.
// R16 - Inputs are sampled every 2 ms with 10 ms debounce.
// R17 - Input query reports all 48 channels regardless of mode.
// R18 - Switching a channel into PWM clears its active interval to zero.
// R19 - Module reset drives outputs inactive and returns channels to standard mode.
// R20 - Debounced state changes only after five agreeing consecutive samples.
// R21 - Error flag stays set until the flag clear action; the code also clears it on module reset.
`timescale 1ns/10ps
module dpmiq_top
  import dpmiq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = dpmiq_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                           mclk_i,
  input  wire logic                           resetn_i,
  input  wire logic                           module_reset_i,
  input  wire logic                           cmd_valid_i,
  input  wire logic                           cmd_start_i,
  input  wire logic [7:0]                     cmd_byte_i,
  output logic                                cmd_ready_o,
  output logic                                rsp_valid_o,
  output logic                                rsp_last_o,
  output logic      [7:0]                     rsp_byte_o,
  input  wire logic                           mode_load_i,
  input  wire logic [dpmiq_pkg::PWM_CH-1:0]   mode_bits_i,
  input  wire logic                           flag_clear_i,
  input  wire logic [dpmiq_pkg::NUM_CH-1:0]   din_i,
  output logic      [dpmiq_pkg::PWM_CH-1:0]   pwm_out_o,
  output logic      [dpmiq_pkg::PWM_CH-1:0]   channel_mode_bits_o,
  output logic                                command_error_flag_o
);
  import dpmiq_pkg::*;

  // Tick divider.
  logic [TICK_CNT_W-1:0] tick_cnt_reg;
  logic [TICK_CNT_W-1:0] tick_cnt_next;
  logic                  tick_reg;
  logic                  tick_next;

  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if (tick_cnt_reg == TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next     = 1'b1;  // [R16]
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // Channel modes; a rising mode bit tells the channel to start from cleared timing.
  logic [PWM_CH-1:0] mode_reg;
  logic [PWM_CH-1:0] mode_next;
  logic [PWM_CH-1:0] enter_vec;

  always_comb begin
    mode_next = mode_reg;
    enter_vec = '0;
    if (module_reset_i) begin
      mode_next = MODE_RST;  // [R2] [R19]
    end else if (mode_load_i) begin
      mode_next = mode_bits_i;
      enter_vec = mode_bits_i & ~mode_reg;  // [R18]
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg <= MODE_RST;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Input synchroniser and debounce; a short glitch restarts the agreement count.
  logic [NUM_CH-1:0] din_meta_reg;
  logic [NUM_CH-1:0] din_sync_reg;
  logic [NUM_CH-1:0] db_vec;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      din_meta_reg <= din_i;
      din_sync_reg <= din_meta_reg;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_db
    logic [DB_CNT_W-1:0] cnt_reg;
    logic [DB_CNT_W-1:0] cnt_next;
    logic                state_reg;
    logic                state_next;

    always_comb begin
      cnt_next   = cnt_reg;
      state_next = state_reg;
      if (tick_reg) begin
        if (din_sync_reg[g] == state_reg) begin
          cnt_next = '0;
        end else if (cnt_reg == DB_CNT_W'(DB_SAMPLES - 1)) begin
          cnt_next   = '0;
          state_next = din_sync_reg[g];  // [R20] [R16]
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        cnt_reg   <= '0;
        state_reg <= 1'b0;
      end else begin
        cnt_reg   <= cnt_next;
        state_reg <= state_next;
      end
    end

    assign db_vec[g] = state_reg;
  end

  // Command interpreter.
  dpmiq_state_t      state_reg;
  dpmiq_state_t      state_next;
  logic [7:0]        op_reg;
  logic [7:0]        op_next;
  logic [1:0]        argc_reg;
  logic [1:0]        argc_next;
  logic [7:0]        arg0_reg;
  logic [7:0]        arg0_next;
  logic [7:0]        arg1_reg;
  logic [7:0]        arg1_next;
  logic [7:0]        buf_reg [RSP_MAX];
  logic [7:0]        buf_next [RSP_MAX];
  logic [2:0]        len_reg;
  logic [2:0]        len_next;
  logic [2:0]        idx_reg;
  logic [2:0]        idx_next;
  logic              ready_next;
  logic              rsp_valid_next;
  logic              rsp_last_next;
  logic [7:0]        rsp_byte_next;
  logic              err_reg;
  logic              err_next;
  logic              bad_ch;
  logic              prog_fire;
  logic [7:0]        ch;
  logic [1:0]        need;
  logic              take;
  logic [PWM_CH-1:0] wr_vec;
  logic [7:0]        act_iv [PWM_CH];
  logic [7:0]        inact_iv [PWM_CH];
  wire  [PWM_CH-1:0] lvl_vec;

  assign take = cmd_valid_i && cmd_ready_o;
  assign need = (op_reg == OP_PWM_PROGRAM) ? PWM_PROG_ARGS : PWM_QUERY_ARGS;
  assign ch   = (op_reg == OP_PWM_PROGRAM) ? arg0_reg : cmd_byte_i;

  always_comb begin
    state_next     = state_reg;
    op_next        = op_reg;
    argc_next      = argc_reg;
    arg0_next      = arg0_reg;
    arg1_next      = arg1_reg;
    buf_next       = buf_reg;
    len_next       = len_reg;
    idx_next       = idx_reg;
    rsp_valid_next = 1'b0;
    rsp_last_next  = 1'b0;
    rsp_byte_next  = 8'h00;
    bad_ch         = 1'b0;
    prog_fire      = 1'b0;
    case (state_reg)
      ST_IDLE, ST_ARGS: begin
        if (take && cmd_start_i) begin
          op_next   = cmd_byte_i;
          argc_next = '0;
          idx_next  = '0;
          case (cmd_byte_i)
            OP_MODE_QUERY: begin
              buf_next[0] = mode_reg[MODE_QCH-1:0];  // [R1]
              len_next    = MODE_RSP_LEN;
              state_next  = ST_RESP;
            end
            OP_INPUT_QUERY: begin
              for (int k = 0; k < RSP_MAX; k++) begin
                buf_next[k] = db_vec[8*k +: 8];  // [R14] [R15] [R17]
              end
              len_next   = INPUT_RSP_LEN;
              state_next = ST_RESP;
            end
            OP_PWM_PROGRAM, OP_PWM_QUERY: begin
              state_next = ST_ARGS;  // [R3] [R10]
            end
            default: begin
              state_next = ST_IDLE;
            end
          endcase
        end else if (take && state_reg == ST_ARGS) begin
          argc_next = argc_reg + 2'h1;
          if (argc_reg == 2'h0) begin
            arg0_next = cmd_byte_i;
          end
          if (argc_reg == 2'h1) begin
            arg1_next = cmd_byte_i;
          end
          if (argc_reg + 2'h1 == need) begin
            bad_ch = ch > MAX_PWM_CH;  // [R8] [R11]
            if (op_reg == OP_PWM_PROGRAM) begin
              prog_fire  = !bad_ch;  // [R3] [R8]
              state_next = ST_IDLE;
            end else begin
              buf_next[0] = bad_ch ? 8'h00 : act_iv[ch[4:0]];  // [R10] [R12]
              buf_next[1] = bad_ch ? 8'h00 : inact_iv[ch[4:0]];
              len_next    = PWM_RSP_LEN;
              state_next  = ST_RESP;
            end
          end
        end
      end
      ST_RESP: begin
        rsp_valid_next = 1'b1;
        rsp_byte_next  = buf_reg[idx_reg];
        idx_next       = idx_reg + 3'h1;
        if (idx_reg == len_reg - 3'h1) begin
          rsp_last_next = 1'b1;
          state_next    = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (module_reset_i) begin
      state_next     = ST_IDLE;
      rsp_valid_next = 1'b0;
      rsp_last_next  = 1'b0;
      prog_fire      = 1'b0;
    end
    ready_next = (state_next != ST_RESP);
    // A new illegal channel wins over a clear arriving in the same cycle.
    err_next   = bad_ch || (err_reg && !flag_clear_i && !module_reset_i);  // [R21]
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg   <= ST_IDLE;
      op_reg      <= 8'h00;
      argc_reg    <= '0;
      arg0_reg    <= 8'h00;
      arg1_reg    <= 8'h00;
      buf_reg     <= '{default: 8'h00};
      len_reg     <= '0;
      idx_reg     <= '0;
      cmd_ready_o <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_last_o  <= 1'b0;
      rsp_byte_o  <= 8'h00;
      err_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      argc_reg    <= argc_next;
      arg0_reg    <= arg0_next;
      arg1_reg    <= arg1_next;
      buf_reg     <= buf_next;
      len_reg     <= len_next;
      idx_reg     <= idx_next;
      cmd_ready_o <= ready_next;
      rsp_valid_o <= rsp_valid_next;
      rsp_last_o  <= rsp_last_next;
      rsp_byte_o  <= rsp_byte_next;
      err_reg     <= err_next;
    end
  end

  for (genvar c = 0; c < PWM_CH; c++) begin : g_pwm
    assign wr_vec[c] = prog_fire && (ch == 8'(c));
    dpmiq_pwm_chan u_chan (
      .mclk_i     (mclk_i),
      .resetn_i   (resetn_i),
      .tick_i     (tick_reg),
      .enable_i   (mode_reg[c]),
      .enter_i    (enter_vec[c]),
      .wr_i       (wr_vec[c]),
      .active_i   (arg1_reg),
      .inactive_i (cmd_byte_i),
      .active_o   (act_iv[c]),
      .inactive_o (inact_iv[c]),
      .level_o    (lvl_vec[c])
    );
  end

  assign pwm_out_o            = lvl_vec;
  assign channel_mode_bits_o  = mode_reg;
  assign command_error_flag_o = err_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_mode_take;
    take && cmd_start_i && cmd_byte_i == OP_MODE_QUERY && !module_reset_i;
  endsequence
  sequence s_in_take;
    take && cmd_start_i && cmd_byte_i == OP_INPUT_QUERY && !module_reset_i;
  endsequence
  sequence s_six_bytes;
    (rsp_valid_o && !rsp_last_o) [*5] ##1 (rsp_valid_o && rsp_last_o);
  endsequence

  mode_reply_a: assert property (disable iff (!resetn_i || module_reset_i)  // [R1]
    s_mode_take |-> ##2 rsp_valid_o && rsp_last_o && rsp_byte_o == $past(mode_reg[7:0], 2))
    else $error("mode query reply wrong");
  reset_mode_a: assert property (module_reset_i |=> mode_reg == MODE_RST ##1 pwm_out_o == '0)  // [R2]
    else $error("module reset left a channel in pwm mode or driving");
  input_len_a: assert property (disable iff (!resetn_i || module_reset_i)  // [R14]
    s_in_take |-> ##2 s_six_bytes)
    else $error("input query reply is not six bytes");
  input_data_a: assert property (disable iff (!resetn_i || module_reset_i)  // [R15]
    s_in_take |-> ##2 rsp_byte_o == $past(db_vec[7:0], 2) ##5 rsp_byte_o == $past(db_vec[47:40], 7))
    else $error("input query bytes do not match debounced state");
  db_on_tick_a: assert property ($changed(db_vec) |-> $past(tick_reg))  // [R20]
    else $error("debounced state changed off a sample tick");
  err_cause_a: assert property ($rose(err_reg) |-> $past(bad_ch))  // [R8]
    else $error("error flag set without an illegal channel");
  err_sticky_a: assert property (err_reg && !flag_clear_i && !module_reset_i |=> err_reg)  // [R21]
    else $error("error flag dropped without a clear");
  bad_no_write_a: assert property (bad_ch |-> wr_vec == '0)  // [R8]
    else $error("illegal channel changed pwm timing");

endmodule // dpmiq_top

// >>> verif/dpmiq_client.sv
`timescale 1ns/10ps
module dpmiq_client (
  input  wire logic       mclk_i,
  input  wire logic       cmd_ready_i,
  input  wire logic       rsp_valid_i,
  input  wire logic       rsp_last_i,
  input  wire logic [7:0] rsp_byte_i,
  output logic            cmd_valid_o,
  output logic            cmd_start_o,
  output logic      [7:0] cmd_byte_o
);
  logic [7:0] rsp_q[$];
  int         timeouts;
  int         last_at;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_start_o = 1'b0;
    cmd_byte_o  = 8'h00;
    timeouts    = 0;
    last_at     = 0;
  end

  // Reply bytes stand one cycle each, so every edge with valid high is collected.
  always @(posedge mclk_i) begin
    if (rsp_valid_i === 1'b1) begin
      rsp_q.push_back(rsp_byte_i);
      if (rsp_last_i === 1'b1) last_at = rsp_q.size();
    end
  end

  // The byte is held until an edge sees ready high, then the next one may follow.
  task automatic put(input logic start, input logic [7:0] b);
    int n;
    n = 0;
    cmd_valid_o <= 1'b1;
    cmd_start_o <= start;
    cmd_byte_o  <= b;
    do begin
      @(posedge mclk_i);
      n++;
    end while (cmd_ready_i !== 1'b1 && n < 100);
    if (n >= 100) begin
      timeouts++;
    end
  endtask

  // Opcode first, then its argument bytes in their fixed order.
  // Interval replies are also checked for a channel that is in standard mode.
  task automatic command(input logic [7:0] op, input int nargs, input logic [7:0] a0, a1, a2);
    rsp_q.delete();
    last_at = 0;
    put(1'b1, op);
    if (nargs > 0) put(1'b0, a0);
    if (nargs > 1) put(1'b0, a1);
    if (nargs > 2) put(1'b0, a2);
    cmd_valid_o <= 1'b0;
    cmd_start_o <= 1'b0;
    // A released byte lane shows the complement of the last byte, never the last byte.
    cmd_byte_o  <= ~cmd_byte_o;
    @(posedge mclk_i);
  endtask
endmodule // dpmiq_client

// >>> verif/dio_pwm_mode_input_query_bench.sv
`timescale 1ns/10ps
module dio_pwm_mode_input_query_bench;
  import dpmiq_pkg::*;
  localparam int TK = 8;
  logic              mclk_i, resetn_i, module_reset_i, mode_load_i, flag_clear_i;
  logic              cmd_valid, cmd_start, cmd_ready, rsp_valid, rsp_last, err;
  logic [7:0]        cmd_byte, rsp_byte;
  logic [PWM_CH-1:0] mode_bits, pwm_out, mode_out;
  logic [NUM_CH-1:0] din;
  longint            hi, lo;
  int                n_fail, n_checks;

  initial mclk_i = 1'b0;
  always #25 mclk_i = ~mclk_i;

  dpmiq_top #(.TICK_CYCLES(TK)) uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .module_reset_i(module_reset_i),
    .cmd_valid_i(cmd_valid), .cmd_start_i(cmd_start), .cmd_byte_i(cmd_byte), .cmd_ready_o(cmd_ready),
    .rsp_valid_o(rsp_valid), .rsp_last_o(rsp_last), .rsp_byte_o(rsp_byte), .mode_load_i(mode_load_i),
    .mode_bits_i(mode_bits), .flag_clear_i(flag_clear_i), .din_i(din), .pwm_out_o(pwm_out),
    .channel_mode_bits_o(mode_out), .command_error_flag_o(err));

  dpmiq_client client (.mclk_i(mclk_i), .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid),
    .rsp_last_i(rsp_last), .rsp_byte_i(rsp_byte), .cmd_valid_o(cmd_valid), .cmd_start_o(cmd_start),
    .cmd_byte_o(cmd_byte));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0d ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    n_fail += client.timeouts;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic query(input logic [7:0] op, input int nargs, input logic [7:0] a0, input int nr);
    int n;
    n = 0;
    client.command(op, nargs, a0, 8'h00, 8'h00);
    while (client.rsp_q.size() < nr && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 50) begin
      n_fail++;
      end_of_test();
    end
    check(client.last_at, nr);
  endtask

  task automatic prog(input logic [7:0] ch, input logic [7:0] a, input logic [7:0] i);
    client.command(OP_PWM_PROGRAM, 3, ch, a, i);
    cyc(2);
  endtask

  // Selects 0 mode load, 1 flag clear, 2 module reset; a ref argument may not take a non-blocking write.
  task automatic pulse(input int sel);
    mode_load_i    <= (sel == 0);
    flag_clear_i   <= (sel == 1);
    module_reset_i <= (sel == 2);
    cyc(1);
    mode_load_i    <= 1'b0;
    flag_clear_i   <= 1'b0;
    module_reset_i <= 1'b0;
    cyc(1);
  endtask

  task automatic wait_lvl(input logic l);
    int n;
    n = 0;
    while (pwm_out[0] !== l && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      end_of_test();
    end
  endtask

  // Times one active and the following inactive phase of channel 0, optionally reprogramming mid-phase.
  task automatic measure(input bit rp, input logic [7:0] a, input logic [7:0] i, output longint h, output longint l);
    time t0, t1, t2;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    t0 = $time;
    if (rp) prog(8'h00, a, i);
    wait_lvl(1'b0);
    t1 = $time;
    wait_lvl(1'b1);
    t2 = $time;
    h = (t1 - t0) / 50;
    l = (t2 - t1) / 50;
  endtask

  task automatic low_for(input int ch, input int n);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge mclk_i);
      if (pwm_out[ch] !== 1'b0) h++;
    end
    check(h, 0);
  endtask

  initial begin
    resetn_i = 1'b0; module_reset_i = 1'b0; mode_load_i = 1'b0; flag_clear_i = 1'b0;
    mode_bits = 24'h000000; din = 48'h000000000000; n_fail = 0; n_checks = 0;
    cyc(3);
    resetn_i <= 1'b1;
    cyc(1);
    check(pwm_out, 24'h000000);
    query(OP_MODE_QUERY, 0, 8'h00, 1);
    check(client.rsp_q[0], 8'h00);
    $display("test reset state done");

    mode_bits <= 24'h0000A5;
    pulse(0);
    query(OP_MODE_QUERY, 0, 8'h00, 1);
    check(client.rsp_q[0], 8'hA5);
    query(OP_PWM_QUERY, 1, 8'h00, 2);
    check({client.rsp_q[0], client.rsp_q[1]}, 16'h0001);
    low_for(0, 4 * TK);
    prog(8'h00, 8'h02, 8'h00);
    query(OP_PWM_QUERY, 1, 8'h00, 2);
    check({client.rsp_q[0], client.rsp_q[1]}, 16'h0201);
    $display("test modes and query done");

    measure(1'b0, 8'h00, 8'h00, hi, lo);
    check(hi, 2 * TK);
    check(lo, TK);
    measure(1'b1, 8'h01, 8'h03, hi, lo);
    check(hi, 2 * TK);
    check(lo, 3 * TK);
    measure(1'b0, 8'h00, 8'h00, hi, lo);
    check(hi, TK);
    check(lo, 3 * TK);
    prog(8'h01, 8'h05, 8'h05);
    low_for(1, 12 * TK);
    query(OP_PWM_QUERY, 1, 8'h01, 2);
    check({client.rsp_q[0], client.rsp_q[1]}, 16'h0001);
    prog(8'h00, 8'h00, 8'h05);
    cyc(8 * TK);
    low_for(0, 12 * TK);
    $display("test pwm timing done");

    prog(8'h17, 8'h01, 8'h01);
    check(err, 1'h0);
    prog(8'h18, 8'h01, 8'h01);
    check(err, 1'h1);
    query(OP_PWM_QUERY, 1, 8'h00, 2);
    check({client.rsp_q[0], client.rsp_q[1]}, 16'h0005);
    cyc(20);
    check(err, 1'h1);
    pulse(1);
    check(err, 1'h0);
    query(OP_PWM_QUERY, 1, 8'hFF, 2);
    check({client.rsp_q[0], client.rsp_q[1]}, 16'h0000);
    cyc(1);
    check(err, 1'h1);
    pulse(1);
    $display("test error flag done");

    din <= 48'hC3A55A3C0F96;
    cyc(2 * TK);
    query(OP_INPUT_QUERY, 0, 8'h00, 6);
    for (int k = 0; k < 6; k++) check(client.rsp_q[k], 8'h00);
    cyc(8 * TK);
    query(OP_INPUT_QUERY, 0, 8'h00, 6);
    for (int k = 0; k < 6; k++) check(client.rsp_q[k], din[8 * k +: 8]);
    $display("test input query done");

    // Channel 0 is caught in its active phase so the reset has a driving output to silence.
    prog(8'h00, 8'h01, 8'h01);
    wait_lvl(1'b1);
    pulse(2);
    cyc(1);
    check(mode_out, 24'h000000);
    check(pwm_out, 24'h000000);
    query(OP_MODE_QUERY, 0, 8'h00, 1);
    check(client.rsp_q[0], 8'h00);
    $display("test module reset done");
    end_of_test();
  end
endmodule // dio_pwm_mode_input_query_bench
